// ### rtl/mxe_core.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Decode and execute five data-move / exclusive-or instructions
// Assumes: File register array answers a read in the same mclk cycle
// Notes:   One instruction per four-quarter cycle; unknown words do nothing
//////////////////////////////////////////////////////////////////////////////
module mxe_core
    import mxe_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // Instruction fetch
    input  wire logic                   instr_valid,
    input  wire logic [`MXE_WORD_W-1:0] instr_word,
    output      logic                   instr_taken,
    output      logic                   unsupported,
    // File register ports
    output      mxe_file_read_t         file_read,
    input  wire logic [`MXE_DATA_W-1:0] file_read_data,
    output      mxe_file_write_t        file_write,
    // Core state
    output      logic [`MXE_DATA_W-1:0] accumulator,
    output      logic                   zero_flag,
    output      mxe_phase_t             phase,
    output      logic                   cycle_start
);

    //////////////////////////////////////////////////////////////////////////
    // Time base: one quarter is one oscillator period, never under one mclk
    // Limitation: an oscillator period that is not a whole number of mclk periods
    // is rounded down, so the instruction cycle then runs slightly fast

    localparam int OSC_CYC_RAW = `MXE_OSC_PERIOD_NS / `MXE_MCLK_PERIOD_NS;
    localparam int OSC_CYC     = (OSC_CYC_RAW < 1) ? 1 : OSC_CYC_RAW;
    localparam logic [`MXE_DIV_W-1:0] DIV_LAST = `MXE_DIV_W'(OSC_CYC - 1);

    mxe_state_t state;
    mxe_state_t next_state;

    logic                   tick;
    logic [5:0]             opc6;
    logic [`MXE_DATA_W-1:0] calc;
    logic                   dec_copy;
    logic                   dec_xor_reg;
    logic                   dec_store;
    logic                   dec_xor_imm;
    logic                   dec_load_imm;
    logic                   dec_reads_file;
    mxe_op_t                dec_op;

    assign tick = (state.div == DIV_LAST);
    assign opc6 = instr_word[`MXE_WORD_W-1 -: 6];

    //////////////////////////////////////////////////////////////////////////
    // Word decode: the top six bits pick the operation (store also needs bit 7, load only the top four), the rest are operands

    assign dec_copy       = (opc6 == `MXE_OPC_COPY);
    assign dec_xor_reg    = (opc6 == `MXE_OPC_XOR_REG);
    assign dec_store      = (opc6 == `MXE_OPC_STORE) && instr_word[`MXE_STORE_BIT];
    assign dec_xor_imm    = (opc6 == `MXE_OPC_XOR_IMM);
    // Bits 9:8 of a load are don't-care: only the top four bits are compared
    assign dec_load_imm   = (opc6[5:2] == `MXE_OPC_LOAD_IMM);
    // Store reads its register in phase two too, though it never uses the byte
    assign dec_reads_file = dec_copy || dec_xor_reg || dec_store;

    // Exact opcodes are tested before the wider load pattern
    always_comb begin
        if (dec_copy) begin
            dec_op = OP_COPY;
        end else if (dec_xor_reg) begin
            dec_op = OP_XOR_REG;
        end else if (dec_store) begin
            dec_op = OP_STORE;
        end else if (dec_xor_imm) begin
            dec_op = OP_XOR_IMM;
        end else if (dec_load_imm) begin
            dec_op = OP_LOAD_IMM;
        end else begin
            dec_op = OP_NONE;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Result of the decoded operation, used in phase three

    always_comb begin
        case (state.op)
            OP_COPY:     calc = state.operand;
            OP_LOAD_IMM: calc = state.operand;
            OP_STORE:    calc = state.acc;
            OP_XOR_IMM:  calc = state.acc ^ state.operand;
            OP_XOR_REG:  calc = state.acc ^ state.operand;
            default:     calc = state.acc;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state             = state;
        next_state.taken       = 1'b0;
        next_state.unsupported = 1'b0;
        next_state.cycle_start = 1'b0;
        next_state.wr.en       = 1'b0;

        // Four quarters per instruction cycle, each one divider period
        next_state.div = tick ? '0 : state.div + `MXE_DIV_W'(1);

        if (tick) begin
            case (state.phase)
                PH_ONE: begin
                    // Decode: word is taken at the end of phase one
                    next_state.phase   = PH_TWO;
                    next_state.op      = instr_valid ? dec_op : OP_NONE;
                    next_state.dest    = instr_word[`MXE_DEST_BIT];
                    next_state.idx     = instr_word[`MXE_IDX_W-1:0];
                    next_state.literal = instr_word[`MXE_DATA_W-1:0];
                    next_state.taken   = instr_valid;
                    // A valid word outside the five runs as a no-op and is flagged
                    next_state.unsupported = instr_valid && (dec_op == OP_NONE);
                    // Register-read slot opens for every file-register form
                    next_state.rd.addr = instr_word[`MXE_IDX_W-1:0];
                    next_state.rd.en   = instr_valid && dec_reads_file;
                end
                PH_TWO: begin
                    // Operand fetch: literal or file register
                    next_state.phase = PH_THREE;
                    next_state.rd.en = 1'b0;
                    // Literal forms ignore file_read_data, whatever it shows then
                    if (state.op == OP_LOAD_IMM || state.op == OP_XOR_IMM) begin
                        next_state.operand = state.literal;
                    end else begin
                        next_state.operand = file_read_data;
                    end
                end
                PH_THREE: begin
                    // Compute and stage the destination
                    next_state.phase     = PH_FOUR;
                    next_state.result    = calc;
                    next_state.to_file   = (state.op == OP_STORE) ||
                                           ((state.op == OP_COPY || state.op == OP_XOR_REG) && state.dest);
                    next_state.to_acc    = (state.op == OP_LOAD_IMM) || (state.op == OP_XOR_IMM) ||
                                           ((state.op == OP_COPY || state.op == OP_XOR_REG) && !state.dest);
                    // Load and store leave the flags alone
                    next_state.hits_zero = (state.op == OP_COPY) || (state.op == OP_XOR_IMM) ||
                                           (state.op == OP_XOR_REG);
                    next_state.wr.en     = (state.op == OP_STORE) ||
                                           ((state.op == OP_COPY || state.op == OP_XOR_REG) && state.dest);
                    next_state.wr.addr   = state.idx;
                    next_state.wr.data   = calc;
                end
                default: begin
                    // Phase four ends: next instruction cycle begins
                    next_state.phase       = PH_ONE;
                    next_state.cycle_start = 1'b1;
                    next_state.op          = OP_NONE;
                    next_state.to_acc      = 1'b0;
                    next_state.to_file     = 1'b0;
                    next_state.hits_zero   = 1'b0;
                end
            endcase
        end

        // Commit on the first mclk of phase four, with the write pulse
        // Accumulator and zero flag move together, so no reader sees them disagree
        if (state.wr.en || (state.phase == PH_FOUR && state.div == '0)) begin
            if (state.to_acc) begin
                next_state.acc = state.result;
            end
            if (state.hits_zero) begin
                next_state.zero = (state.result == '0);
            end
            next_state.to_acc    = 1'b0;
            next_state.hits_zero = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            // Reset lands in idle phase one with no cycle_start pulse
            state       <= '0;
            state.phase <= PH_ONE;
            state.op    <= OP_NONE;
            state.acc   <= `MXE_ACC_RESET;
            state.zero  <= `MXE_ZERO_RESET;
        end else begin
            state <= next_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign instr_taken = state.taken;
    assign unsupported = state.unsupported;
    assign file_read   = state.rd;
    assign file_write  = state.wr;
    assign accumulator = state.acc;
    assign zero_flag   = state.zero;
    assign phase       = state.phase;
    assign cycle_start = state.cycle_start;

endmodule : mxe_core

// ### common/mxe_regs.svh
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the move / exclusive-or execute block
// Assumes: mclk at 250 MHz; one oscillator period per quarter of a cycle
// Notes:   Times are kept in ns; cycle counts are derived in the core
//////////////////////////////////////////////////////////////////////////////
`ifndef MXE_REGS_SVH
`define MXE_REGS_SVH

// Clock and time base
`define MXE_MCLK_PERIOD_NS   4
`define MXE_OSC_PERIOD_NS    16
`define MXE_QUARTERS         4
`define MXE_DIV_W            8

// Instruction word fields
`define MXE_WORD_W           14
`define MXE_DATA_W           8
`define MXE_IDX_W            7
`define MXE_DEST_BIT         7
`define MXE_STORE_BIT        7

// Opcode prefixes (top bits of the word)
`define MXE_OPC_COPY         6'h08
`define MXE_OPC_XOR_REG      6'h06
`define MXE_OPC_STORE        6'h00
`define MXE_OPC_XOR_IMM      6'h3A
`define MXE_OPC_LOAD_IMM     4'hC

// Reset values
`define MXE_ACC_RESET        8'h00
`define MXE_ZERO_RESET       1'h0

`endif

// ### common/mxe_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Types shared by the execute core and its bench
// Assumes: mxe_regs.svh provides the widths
// Notes:   Phase codes are Gray along the normal quarter sequence
//////////////////////////////////////////////////////////////////////////////
`include "mxe_regs.svh"

package mxe_pkg;

    typedef enum logic [1:0] {
        PH_ONE   = 2'h0,
        PH_TWO   = 2'h1,
        PH_THREE = 2'h3,
        PH_FOUR  = 2'h2
    } mxe_phase_t;

    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_COPY      = 3'h1,
        OP_LOAD_IMM  = 3'h2,
        OP_STORE     = 3'h3,
        OP_XOR_IMM   = 3'h4,
        OP_XOR_REG   = 3'h5
    } mxe_op_t;

    typedef struct packed {
        logic                  en;
        logic [`MXE_IDX_W-1:0] addr;
    } mxe_file_read_t;

    typedef struct packed {
        logic                   en;
        logic [`MXE_IDX_W-1:0]  addr;
        logic [`MXE_DATA_W-1:0] data;
    } mxe_file_write_t;

    typedef struct packed {
        logic [`MXE_DIV_W-1:0]  div;
        mxe_phase_t             phase;
        mxe_op_t                op;
        logic                   dest;
        logic [`MXE_IDX_W-1:0]  idx;
        logic [`MXE_DATA_W-1:0] literal;
        logic [`MXE_DATA_W-1:0] operand;
        logic [`MXE_DATA_W-1:0] result;
        logic                   to_acc;
        logic                   to_file;
        logic                   hits_zero;
        logic [`MXE_DATA_W-1:0] acc;
        logic                   zero;
        mxe_file_read_t         rd;
        mxe_file_write_t        wr;
        logic                   taken;
        logic                   unsupported;
        logic                   cycle_start;
    } mxe_state_t;

endpackage : mxe_pkg

// ### sim/mxe_core_sva.sv
// Purpose: Timing and result properties of the execute core
// Assumes: Sees only mxe_core ports; one mclk domain
// Notes:   Cycle figures assume a four-mclk quarter, sixteen mclk per cycle
`include "mxe_regs.svh"
module mxe_core_sva
    import mxe_pkg::*;
(
    // All watched ports
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic [`MXE_WORD_W-1:0] instr_word,
    input  wire logic                   instr_taken,
    input  wire logic                   unsupported,
    input  wire mxe_file_read_t         file_read,
    input  wire mxe_file_write_t        file_write,
    input  wire logic [`MXE_DATA_W-1:0] accumulator,
    input  wire logic                   zero_flag,
    input  wire mxe_phase_t             phase,
    input  wire logic                   cycle_start
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    taken_phase_a: assert property (instr_taken |-> phase == PH_TWO && $past(phase) == PH_ONE)
        else $error("word taken off phase two start");
    refuse_taken_a: assert property (unsupported |-> instr_taken)
        else $error("unsupported without taken");
    read_window_a: assert property ($rose(file_read.en) |-> phase == PH_TWO ##1
        (file_read.en && $stable(file_read.addr))[*3] ##1 !file_read.en) else $error("read window wrong");
    write_slot_a: assert property (file_write.en |->
        phase == PH_FOUR && $past(phase) == PH_THREE ##1 !file_write.en) else $error("write outside phase four start");
    quarter_len_a: assert property ($changed(phase) |=> $stable(phase)[*3])
        else $error("quarter not four mclk");
    cycle_len_a: assert property (cycle_start |-> phase == PH_ONE ##16 cycle_start)
        else $error("instruction cycle not 16 mclk");
    commit_time_a: assert property (($changed(accumulator) || $changed(zero_flag)) |->
        phase == PH_FOUR && $past(phase) == PH_FOUR && $past(phase, 2) == PH_THREE) else $error("late commit");
    store_write_a: assert property (instr_taken && $past(instr_word[13:7]) == 7'h01 |-> ##8
        file_write.en && file_write.data == accumulator && file_write.addr == $past(instr_word[6:0], 9))
        else $error("store write wrong");
    xor_imm_a: assert property (instr_taken && $past(instr_word[13:8]) == 6'h3A |-> ##9 zero_flag ==
        (accumulator == 8'h00) && accumulator == ($past(accumulator, 9) ^ $past(instr_word[7:0], 10)))
        else $error("xor immediate result wrong");
    load_keep_a: assert property (instr_taken && $past(instr_word[13:10]) == 4'hC |-> ##9
        accumulator == $past(instr_word[7:0], 10) && zero_flag == $past(zero_flag, 9)) else $error("load wrong");
endmodule : mxe_core_sva
////////////////////////////////////////////////////////////////////////////////
bind mxe_core mxe_core_sva chk (.mclk(mclk), .reset_n(reset_n), .instr_word(instr_word),
    .instr_taken(instr_taken), .unsupported(unsupported), .file_read(file_read), .file_write(file_write),
    .accumulator(accumulator), .zero_flag(zero_flag), .phase(phase), .cycle_start(cycle_start));

// ### sim/test_move_xor_instr_exec.sv
// Purpose: Self-checking bench for the move / exclusive-or execute core
// Assumes: The bench holds the 128-byte file register array
// Notes:   Each instruction runs to the next cycle_start pulse
`include "mxe_regs.svh"
module test_move_xor_instr_exec
    import mxe_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   mclk, reset_n, instr_valid, instr_taken, unsupported;
    logic [`MXE_WORD_W-1:0] instr_word;
    logic [`MXE_DATA_W-1:0] file_read_data, accumulator;
    logic [`MXE_DATA_W-1:0] mem [128];
    logic                   zero_flag, cycle_start, seen_taken, seen_unsup;
    mxe_file_read_t         file_read;
    mxe_file_write_t        file_write;
    mxe_phase_t             phase;
    int                     fail_count, comparisons;
    ////////////////////////////////////////////////////////////////////////////
    // Idle read lines show the inverse so a stale byte cannot pass
    assign file_read_data = file_read.en ? mem[file_read.addr] : ~mem[file_read.addr];
    always @(posedge mclk) begin
        if (file_write.en === 1'b1) mem[file_write.addr] <= file_write.data;
    end
    mxe_core dut (.mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_taken(instr_taken), .unsupported(unsupported), .file_read(file_read),
        .file_read_data(file_read_data), .file_write(file_write), .accumulator(accumulator),
        .zero_flag(zero_flag), .phase(phase), .cycle_start(cycle_start));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic run(input logic v, input logic [13:0] w, input logic [7:0] a, input logic z);
        int n;
        {instr_valid, instr_word, seen_taken, seen_unsup} = {v, w, 2'b00};
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            #1;
            seen_taken |= instr_taken === 1'b1;
            seen_unsup |= unsupported === 1'b1;
            if (cycle_start === 1'b1) break;
        end
        if (n == 40) begin
            fail_count++;
            $display("CHECK FAILED cycle_start expected 1 seen 0");
            summarize();
        end else begin
            chk("cycle_mclk", 8'h0F, n[7:0]);
            chk("instr_taken", {7'h00, v}, {7'h00, seen_taken});
            chk("accumulator", a, accumulator);
            chk("zero_flag", {7'h00, z}, {7'h00, zero_flag});
        end
    endtask : run
    task automatic test_imm();
        run(1'b1, 14'h335A, 8'h5A, 1'b0);
        run(1'b1, 14'h3A5A, 8'h00, 1'b1);
        run(1'b1, 14'h3100, 8'h00, 1'b1);
        run(1'b1, 14'h30B5, 8'hB5, 1'b1);
        run(1'b1, 14'h3AAF, 8'h1A, 1'b0);
        $display("test_imm done");
    endtask : test_imm
    task automatic test_store_copy();
        run(1'b1, 14'h3A1A, 8'h00, 1'b1);
        run(1'b1, 14'h304F, 8'h4F, 1'b1);
        run(1'b1, 14'h00FF, 8'h4F, 1'b1);
        chk("file_127", 8'h4F, mem[127]);
        run(1'b1, 14'h08FF, 8'h4F, 1'b0);
        run(1'b1, 14'h0885, 8'h4F, 1'b1);
        chk("file_5", 8'h00, mem[5]);
        run(1'b1, 14'h087F, 8'h4F, 1'b0);
        run(1'b1, 14'h0805, 8'h00, 1'b1);
        $display("test_store_copy done");
    endtask : test_store_copy
    task automatic test_xor_reg();
        run(1'b1, 14'h30B5, 8'hB5, 1'b1);
        run(1'b1, 14'h0683, 8'hB5, 1'b0);
        chk("file_3", 8'h1A, mem[3]);
        run(1'b1, 14'h0603, 8'hAF, 1'b0);
        run(1'b1, 14'h0604, 8'h00, 1'b1);
        $display("test_xor_reg done");
    endtask : test_xor_reg
    task automatic test_refuse();
        run(1'b1, 14'h3B00, 8'h00, 1'b1);
        chk("unsupported", 8'h01, {7'h00, seen_unsup});
        run(1'b0, 14'h30FF, 8'h00, 1'b1);
        chk("unsupported", 8'h00, {7'h00, seen_unsup});
        $display("test_refuse done");
    endtask : test_refuse
    task automatic summarize();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {fail_count, comparisons} = '0;
        {reset_n, instr_valid, instr_word} = '0;
        foreach (mem[i]) mem[i] = 8'hFF;
        {mem[3], mem[4], mem[5]} = {8'hAF, 8'hAF, 8'h00};
        repeat (2) @(posedge mclk);
        #1;
        chk("accumulator", 8'h00, accumulator);
        reset_n = 1'b1;
        test_imm();
        test_store_copy();
        test_xor_reg();
        test_refuse();
        summarize();
    end
endmodule : test_move_xor_instr_exec
